// file: core/tcep_top.sv
// Channel enable and polarity register block with four channels
//
// Contract
// - In output mode a polarity bit of 0 makes high the active level and 1 makes low the active level.
// - In input mode with both polarity bits 0 the rising filtered edge is active and nothing is inverted.
// - In input mode with polarity 1 and complementary 0 the falling edge is active and the signal is inverted.
// - The polarity pair picks the active edge for either input source, and software avoids the reserved pairs; the complementary bit is ignored here.
// - Polarity and complementary bits cannot change while the lock level is binary 11 or 10.
// - In output mode the enable bit lets the output reach its active state and clearing it disables the channel.
// - In input mode the enable bit permits capture and no capture happens while it is clear.
// - Enable bits sit at positions 0, 4, 8 and 12, one per channel, each acting alike.
// - Polarity bits sit at positions 1, 5, 9 and 13, one per channel, each acting alike.
// - Complementary polarity bits sit at positions 3, 7, 11 and 15, one per channel.
// - The capture edge prescaler is held in reset while the channel enable is clear.
`timescale 1ns/100ps
`include "tcep_map.svh"
module tcep_top #(
  parameter int CHANNELS = 4,
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register bus
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Timer core
  input wire logic [1:0] lockLevel,
  input wire logic [CHANNELS-1:0] chanOutMode,
  input wire logic [CHANNELS-1:0] chanRefOut,
  input wire logic [CHANNELS-1:0] chanFiltIn,
  input wire tcep_pkg::tcep_psc_t [CHANNELS-1:0] chanCapPsc,
  // Channel results
  output logic [CHANNELS-1:0] chanOut,
  output logic [CHANNELS-1:0] chanOutEn,
  output logic [CHANNELS-1:0] chanTrig,
  output logic [CHANNELS-1:0] chanCapEvt
);
  import tcep_pkg::*;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a,
    input logic [7:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction : hit

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  tcep_bus_st_t st_ff, nxt_st;
  logic [31:0] ctl_ff, nxt_ctl;
  logic [31:0] rd_ff, nxt_rd;
  logic locked;
  logic wrNow;
  logic [31:0] wrMask;
  logic [31:0] statusWord;

  // ---------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------
  assign avs_waitrequest = (avs_read | avs_write) & (st_ff != TCEP_ACK);
  assign avs_readdata = rd_ff;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_rd = rd_ff;
    case (st_ff)
      TCEP_IDLE:
      begin
        if (avs_read || avs_write)
        begin
          nxt_st = TCEP_ACK;
          if (avs_read && hit(avs_address, `TCEP_CTL_OFS))
          begin
            nxt_rd = ctl_ff;
          end
          else if (avs_read && hit(avs_address, `TCEP_STAT_OFS))
          begin
            nxt_rd = statusWord;
          end
          else
          begin
            nxt_rd = 32'h00000000;
          end
        end
      end
      TCEP_ACK:
      begin
        nxt_st = TCEP_IDLE;
      end
      default:
      begin
        nxt_st = TCEP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_ff <= TCEP_IDLE;
      rd_ff <= `TCEP_STAT_RST;
    end
    else
    begin
      st_ff <= nxt_st;
      rd_ff <= nxt_rd;
    end
  end

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  assign locked = lockLevel[1];
  assign wrNow = avs_write && (st_ff == TCEP_ACK) &&
    hit(avs_address, `TCEP_CTL_OFS);

  always_comb
  begin
    // Locked: only enables writable, no error raised
    wrMask = (locked ? `TCEP_EN_MASK : `TCEP_ALL_MASK) &
      lane_mask(avs_byteenable);
    nxt_ctl = ctl_ff;
    if (wrNow)
    begin
      nxt_ctl = (ctl_ff & ~wrMask) | (avs_writedata & wrMask);
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ctl_ff <= `TCEP_CTL_RST;
    end
    else
    begin
      ctl_ff <= nxt_ctl;
    end
  end

  // ---------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++)
    begin : g_ch
      tcep_chan_if cif ();
      assign cif.en = ctl_ff[gi*`TCEP_CH_STRIDE+`TCEP_EN_BIT];
      assign cif.pol = ctl_ff[gi*`TCEP_CH_STRIDE+`TCEP_POL_BIT];
      assign cif.cpol = ctl_ff[gi*`TCEP_CH_STRIDE+`TCEP_CPOL_BIT];
      assign cif.outMode = chanOutMode[gi];
      assign cif.refOut = chanRefOut[gi];
      assign cif.filtIn = chanFiltIn[gi];
      assign cif.psc = chanCapPsc[gi];
      assign chanOut[gi] = cif.out;
      assign chanOutEn[gi] = cif.outEn;
      assign chanTrig[gi] = cif.trig;
      assign chanCapEvt[gi] = cif.capEvt;
      tcep_channel u_ch (
        .clk_sys(clk_sys),
        .rst(rst),
        .cif(cif)
      );
    end
  endgenerate

  // Status word: outputs, triggers, lock state
  always_comb
  begin
    statusWord = 32'h00000000;
    statusWord[CHANNELS-1:0] = chanOut;
    statusWord[CHANNELS+3:4] = chanTrig;
    statusWord[8] = locked;
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_ctl_write;
    avs_write && !avs_waitrequest && hit(avs_address, `TCEP_CTL_OFS) &&
      avs_byteenable[1:0] == 2'h3;
  endsequence

  sequence s_locked_write;
    s_ctl_write and locked;
  endsequence

  sequence s_open_write;
    s_ctl_write and !locked;
  endsequence

  a_lock_pol: assert property (@(posedge clk_sys) disable iff (rst)
    s_locked_write |=> ((ctl_ff & `TCEP_POL_MASK) ==
      ($past(ctl_ff) & `TCEP_POL_MASK)))
    else $error("locked polarity bits changed");
  a_lock_enable: assert property (@(posedge clk_sys) disable iff (rst)
    s_locked_write |=> ((ctl_ff & `TCEP_EN_MASK) ==
      ($past(avs_writedata) & `TCEP_EN_MASK)))
    else $error("enable bits not written under lock");
  a_en_pos: assert property (@(posedge clk_sys) disable iff (rst)
    s_ctl_write |=> ##1 ({g_ch[3].cif.en, g_ch[2].cif.en, g_ch[1].cif.en,
      g_ch[0].cif.en} == {$past(avs_writedata[12], 2),
      $past(avs_writedata[8], 2), $past(avs_writedata[4], 2),
      $past(avs_writedata[0], 2)}))
    else $error("enable bit position wrong");
  a_pol_pos: assert property (@(posedge clk_sys) disable iff (rst)
    s_open_write |=> ({g_ch[3].cif.pol, g_ch[2].cif.pol, g_ch[1].cif.pol,
      g_ch[0].cif.pol} == {$past(avs_writedata[13]),
      $past(avs_writedata[9]), $past(avs_writedata[5]),
      $past(avs_writedata[1])}))
    else $error("polarity bit position wrong");
  a_cpol_pos: assert property (@(posedge clk_sys) disable iff (rst)
    s_open_write |=> ({g_ch[3].cif.cpol, g_ch[2].cif.cpol,
      g_ch[1].cif.cpol, g_ch[0].cif.cpol} ==
      {$past(avs_writedata[15]), $past(avs_writedata[11]),
      $past(avs_writedata[7]), $past(avs_writedata[3])}))
    else $error("complementary bit position wrong");
  a_cpol_ignored: assert property (@(posedge clk_sys) disable iff (rst)
    (!chanOutMode[0] && g_ch[0].cif.cpol && $stable(chanFiltIn[0]) &&
     $stable(g_ch[0].cif.pol)) |=>
      (chanTrig[0] == ($past(chanFiltIn[0]) ^ $past(g_ch[0].cif.pol))))
    else $error("reserved pair changed input polarity");
  a_bus_answer: assert property (@(posedge clk_sys) disable iff (rst)
    (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
    else $error("bus answer too late");
  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (ctl_ff & ~`TCEP_ALL_MASK) == 32'h00000000)
    else $error("reserved control bits set");
  a_rd_ctl: assert property (@(posedge clk_sys) disable iff (rst)
    (avs_read && !avs_waitrequest && hit(avs_address, `TCEP_CTL_OFS)) |->
      (avs_readdata == ctl_ff))
    else $error("control read data wrong");
  a_rd_stat: assert property (@(posedge clk_sys) disable iff (rst)
    (avs_read && !avs_waitrequest && hit(avs_address, `TCEP_STAT_OFS)) |->
      (avs_readdata == $past(statusWord)))
    else $error("status read data wrong");
  a_rd_unmapped: assert property (@(posedge clk_sys) disable iff (rst)
    (avs_read && !avs_waitrequest && !hit(avs_address, `TCEP_CTL_OFS) &&
     !hit(avs_address, `TCEP_STAT_OFS)) |-> (avs_readdata == 32'h00000000))
    else $error("unmapped read not zero");
  a_wr_ignored: assert property (@(posedge clk_sys) disable iff (rst)
    (avs_write && !avs_waitrequest && !hit(avs_address, `TCEP_CTL_OFS))
      |=> $stable(ctl_ff))
    else $error("write to other address changed control");
  a_ctl_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !wrNow |=> $stable(ctl_ff))
    else $error("control changed without write");
  a_ack_idle: assert property (@(posedge clk_sys) disable iff (rst)
    ((avs_read || avs_write) && !avs_waitrequest) |=> (st_ff == TCEP_IDLE))
    else $error("bus state not idle after transfer");
  a_one_wait: assert property (@(posedge clk_sys) disable iff (rst)
    ((avs_read || avs_write) && avs_waitrequest) |=> (st_ff == TCEP_ACK))
    else $error("wait state not ended");
  a_open_enable: assert property (@(posedge clk_sys) disable iff (rst)
    s_open_write |=> ((ctl_ff & `TCEP_EN_MASK) ==
      ($past(avs_writedata) & `TCEP_EN_MASK)))
    else $error("enable bits not written");

  // ---------------------------------------------------------------
  // Per-channel checks
  // ---------------------------------------------------------------
  generate
    for (gi = 0; gi < CHANNELS; gi++)
    begin : g_chk
      a_trig_follow: assert property (@(posedge clk_sys)
        disable iff (rst) !$past(rst) |->
          (chanTrig[gi] == $past(chanFiltIn[gi] ^ g_ch[gi].cif.pol)))
        else $error("trigger not polarity adjusted");
      a_out_follow: assert property (@(posedge clk_sys)
        disable iff (rst) !$past(rst) |->
          (chanOut[gi] == $past(chanOutMode[gi] & g_ch[gi].cif.en &
          (chanRefOut[gi] ^ g_ch[gi].cif.pol))))
        else $error("output level wrong");
      a_oe_follow: assert property (@(posedge clk_sys)
        disable iff (rst) !$past(rst) |->
          (chanOutEn[gi] == $past(chanOutMode[gi] & g_ch[gi].cif.en)))
        else $error("output enable wrong");
      a_cap_gated: assert property (@(posedge clk_sys)
        disable iff (rst) chanCapEvt[gi] |->
          $past(g_ch[gi].cif.en & !chanOutMode[gi]))
        else $error("capture while not permitted");
      a_cap_edge: assert property (@(posedge clk_sys)
        disable iff (rst) chanCapEvt[gi] |->
          (chanTrig[gi] && !$past(chanTrig[gi])))
        else $error("capture without active edge");
    end
  endgenerate
endmodule : tcep_top

// file: core/tcep_map.svh
// Register offsets, field positions and reset values of the channel block
`ifndef TCEP_MAP_SVH
`define TCEP_MAP_SVH
`define TCEP_CTL_OFS 8'h20
`define TCEP_STAT_OFS 8'h40
`define TCEP_CH_STRIDE 4
`define TCEP_EN_BIT 0
`define TCEP_POL_BIT 1
`define TCEP_CPOL_BIT 3
`define TCEP_CTL_RST 32'h00000000
`define TCEP_EN_MASK 32'h00001111
`define TCEP_POL_MASK 32'h0000AAAA
`define TCEP_ALL_MASK 32'h0000BBBB
`define TCEP_STAT_RST 32'h00000000
`endif

// file: core/tcep_pkg.sv
// Types shared by the channel block
package tcep_pkg;
  typedef enum logic [0:0] {TCEP_IDLE = 1'h0, TCEP_ACK = 1'h1} tcep_bus_st_t;
  typedef logic [1:0] tcep_psc_t;
  typedef logic [2:0] tcep_cnt_t;
endpackage : tcep_pkg

// file: core/tcep_chan_if.sv
// Carrier between the register block and one channel
`timescale 1ns/100ps
interface tcep_chan_if;
  logic en;
  logic pol;
  logic cpol;
  logic outMode;
  logic refOut;
  logic filtIn;
  tcep_pkg::tcep_psc_t psc;
  logic out;
  logic outEn;
  logic trig;
  logic capEvt;
  modport top (output en, pol, cpol, outMode, refOut, filtIn, psc,
    input out, outEn, trig, capEvt);
  modport chan (input en, pol, cpol, outMode, refOut, filtIn, psc,
    output out, outEn, trig, capEvt);
endinterface : tcep_chan_if

// file: core/tcep_channel.sv
// One capture/compare channel: polarity, enable and capture prescaler
`timescale 1ns/100ps
module tcep_channel (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Channel carrier
  tcep_chan_if.chan cif
);
  import tcep_pkg::*;

  // ---------------------------------------------------------------
  // Edge, prescaler and output logic
  // ---------------------------------------------------------------
  function automatic tcep_cnt_t last_edge(input tcep_psc_t psc);
    case (psc)
      2'h0: last_edge = 3'h0;
      2'h1: last_edge = 3'h1;
      2'h2: last_edge = 3'h3;
      default: last_edge = 3'h7;
    endcase
  endfunction : last_edge

  logic sig;
  logic actEdge;
  logic capOk;
  logic prev_ff, nxt_prev;
  tcep_cnt_t cnt_ff, nxt_cnt;
  logic cap_ff, nxt_cap;
  logic out_ff, nxt_out;
  logic oe_ff, nxt_oe;

  always_comb
  begin
    sig = cif.filtIn ^ cif.pol;
    actEdge = sig & ~prev_ff;
    capOk = cif.en & ~cif.outMode;
    nxt_prev = sig;
    nxt_cnt = cnt_ff;
    nxt_cap = 1'b0;
    if (!cif.en)
    begin
      nxt_cnt = 3'h0;
    end
    else if (capOk && actEdge)
    begin
      nxt_cap = (cnt_ff == last_edge(cif.psc));
      nxt_cnt = nxt_cap ? 3'h0 : cnt_ff + 3'h1;
    end
    nxt_oe = cif.outMode & cif.en;
    nxt_out = nxt_oe & (cif.refOut ^ cif.pol);
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      prev_ff <= 1'b0;
      cnt_ff <= 3'h0;
      cap_ff <= 1'b0;
      out_ff <= 1'b0;
      oe_ff <= 1'b0;
    end
    else
    begin
      prev_ff <= nxt_prev;
      cnt_ff <= nxt_cnt;
      cap_ff <= nxt_cap;
      out_ff <= nxt_out;
      oe_ff <= nxt_oe;
    end
  end

  assign cif.out = out_ff;
  assign cif.outEn = oe_ff;
  assign cif.trig = prev_ff;
  assign cif.capEvt = cap_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_out_level: assert property (@(posedge clk_sys) disable iff (rst)
    (cif.outMode && cif.en && cif.refOut) |=> (cif.out == !$past(cif.pol)))
    else $error("output active level wrong");
  a_rise_capture: assert property (@(posedge clk_sys) disable iff (rst)
    (!cif.outMode && cif.en && !cif.pol && cif.psc == 2'h0 &&
     $rose(cif.filtIn) && $stable(cif.pol)) |=> cif.capEvt)
    else $error("rising edge not captured");
  a_fall_capture: assert property (@(posedge clk_sys) disable iff (rst)
    (!cif.outMode && cif.en && cif.pol && cif.psc == 2'h0 &&
     $fell(cif.filtIn) && $stable(cif.pol)) |=> cif.capEvt ##1 cif.trig)
    else $error("falling edge not captured or not inverted");
  a_out_disable: assert property (@(posedge clk_sys) disable iff (rst)
    !cif.en |=> (!cif.outEn && !cif.out))
    else $error("disabled channel drives output");
  a_no_capture: assert property (@(posedge clk_sys) disable iff (rst)
    (!cif.en || cif.outMode) |=> !cif.capEvt)
    else $error("capture while disabled");
  a_psc_reset: assert property (@(posedge clk_sys) disable iff (rst)
    !cif.en |=> (cnt_ff == 3'h0))
    else $error("prescaler not held in reset");
endmodule : tcep_channel

// file: testbench/tcep_pins_model.sv
// Model of the channel pins: filtered inputs driven, captures counted
`timescale 1ns/100ps
module tcep_pins_model (
  // Clock
  input wire logic clk_sys,
  // Pins
  output logic [3:0] filtIn,
  input wire logic [3:0] capEvt
);
  int capCnt [4];
  initial
  begin
    filtIn = 4'h0;
  end
  // Capture pulse counters
  always @(posedge clk_sys)
  begin
    for (int i = 0; i < 4; i++)
      if (capEvt[i] === 1'b1)
        capCnt[i] <= capCnt[i] + 1;
  end
  task automatic clear_counts;
    @(posedge clk_sys);
    foreach (capCnt[i])
      capCnt[i] <= 0;
  endtask : clear_counts
  task automatic set_pins(input logic [3:0] v);
    @(posedge clk_sys);
    filtIn <= v;
    repeat (3) @(posedge clk_sys);
  endtask : set_pins
  task automatic toggle(input int ch);
    @(posedge clk_sys);
    filtIn[ch] <= ~filtIn[ch];
    repeat (3) @(posedge clk_sys);
  endtask : toggle
endmodule : tcep_pins_model

// file: testbench/timer_channel_enable_polarity_tb.sv
// Self-checking bench of the channel enable and polarity block
`timescale 1ns/100ps
`include "tcep_map.svh"
module timer_channel_enable_polarity_tb;
  import tcep_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avsAddr = 8'h00;
  logic avsRd = 1'b0;
  logic avsWr = 1'b0;
  logic [31:0] avsWd = 32'h00000000;
  logic [31:0] avsRdata;
  logic avsWait;
  logic [1:0] lockLevel = 2'h0;
  logic [3:0] outMode = 4'h0;
  logic [3:0] refOut = 4'h0;
  logic [3:0] filtIn;
  tcep_psc_t [3:0] capPsc = 8'h00;
  logic [3:0] chOut, chOutEn, chTrig, chCap;
  logic [31:0] q, old, nw;
  int failures = 0;
  int cmpCount = 0;
  int seed = 67158;
  always #20 clk_sys = ~clk_sys;

  tcep_top i_dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avsAddr),
    .avs_read(avsRd), .avs_write(avsWr), .avs_writedata(avsWd),
    .avs_byteenable(4'hF), .avs_readdata(avsRdata),
    .avs_waitrequest(avsWait), .lockLevel(lockLevel),
    .chanOutMode(outMode), .chanRefOut(refOut), .chanFiltIn(filtIn),
    .chanCapPsc(capPsc), .chanOut(chOut), .chanOutEn(chOutEn),
    .chanTrig(chTrig), .chanCapEvt(chCap));
  tcep_pins_model i_pins (.clk_sys(clk_sys), .filtIn(filtIn),
    .capEvt(chCap));

  // ------------------------------
  // Tasks and expectations
  // ------------------------------
  task automatic check(input string nm, input logic [31:0] s, e);
    cmpCount++;
    if (s !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, s);
      failures++;
    end
  endtask : check
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk_sys);
    avsAddr <= a;
    avsWd <= d;
    avsRd <= ~w;
    avsWr <= w;
    do @(posedge clk_sys); while (avsWait !== 1'b0);
    q = avsRdata;
    avsRd <= 1'b0;
    avsWr <= 1'b0;
  endtask : bus
  function automatic logic [31:0] exp_ctl(logic [31:0] o, n,
    logic [1:0] lk);
    return lk[1] ? (n & `TCEP_EN_MASK) | (o & `TCEP_POL_MASK)
      : n & `TCEP_ALL_MASK;
  endfunction : exp_ctl
  function automatic logic [3:0] exp_out(logic [3:0] r,
    logic [31:0] c);
    for (int i = 0; i < 4; i++)
      exp_out[i] = c[4*i] & (r[i] ^ c[4*i+1]);
  endfunction : exp_out
  function automatic logic [3:0] en_of(logic [31:0] c);
    return {c[12], c[8], c[4], c[0]};
  endfunction : en_of
  function automatic logic [3:0] pol_of(logic [31:0] c);
    return {c[13], c[9], c[5], c[1]};
  endfunction : pol_of
  task automatic end_of_test;
    $display("Comparisons %0d mismatches %0d", cmpCount, failures);
    if (failures == 0 && cmpCount > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  initial
  begin
    #(40 * 20000);
    failures++;
    end_of_test();
  end

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    bus(0, `TCEP_CTL_OFS, 0);
    check("ctl reset", q, `TCEP_CTL_RST);
    bus(0, `TCEP_STAT_OFS, 0);
    check("stat reset", q, `TCEP_STAT_RST);
    $display("reset test done");
    for (int i = 0; i < 8; i++)
    begin
      nw = $random(seed) & `TCEP_ALL_MASK;
      bus(1, `TCEP_CTL_OFS, nw);
      bus(0, `TCEP_CTL_OFS, 0);
      check("ctl readback", q, nw);
    end
    bus(0, 8'h44, 0);
    check("unmapped read", q, 32'h00000000);
    $display("readback test done");
    for (int lk = 0; lk < 4; lk++)
    begin
      old = $random(seed) & `TCEP_ALL_MASK;
      nw = $random(seed) & `TCEP_ALL_MASK;
      lockLevel <= 2'h0;
      bus(1, `TCEP_CTL_OFS, old);
      lockLevel <= lk[1:0];
      bus(1, `TCEP_CTL_OFS, nw);
      bus(0, `TCEP_CTL_OFS, 0);
      check("locked write", q, exp_ctl(old, nw, lk[1:0]));
      bus(0, `TCEP_STAT_OFS, 0);
      check("lock status", q[8], lk[1]);
    end
    lockLevel <= 2'h0;
    $display("lock test done");
    outMode <= 4'hF;
    for (int i = 0; i < 8; i++)
    begin
      nw = $random(seed) & 32'h00003333;
      bus(1, `TCEP_CTL_OFS, nw);
      refOut <= 4'($random(seed));
      repeat (3) @(posedge clk_sys);
      check("out level", chOut, exp_out(refOut, nw));
      check("out enable", chOutEn, en_of(nw));
      bus(0, `TCEP_STAT_OFS, 0);
      check("out status", q[7:0], {pol_of(nw), exp_out(refOut, nw)});
    end
    $display("output test done");
    outMode <= 4'h0;
    for (int cfg = 0; cfg < 6; cfg++)
    begin
      bus(1, `TCEP_CTL_OFS, 0);
      i_pins.set_pins(4'h0);
      capPsc <= {4{cfg[1] ? 2'h1 : 2'h0}};
      bus(1, `TCEP_CTL_OFS, {4{2'h0, cfg[0], 1'b0}});
      repeat (3) @(posedge clk_sys);
      check("trig invert", chTrig, {4{cfg[0]}});
      i_pins.set_pins({4{cfg[0]}});
      bus(1, `TCEP_CTL_OFS, {4{2'h0, cfg[0], ~cfg[2]}});
      repeat (3) @(posedge clk_sys);
      i_pins.clear_counts();
      for (int ch = 0; ch < 4; ch++)
        repeat (4) i_pins.toggle(ch);
      repeat (3) @(posedge clk_sys);
      for (int ch = 0; ch < 4; ch++)
        check("captures", i_pins.capCnt[ch],
          cfg[2] ? 0 : (cfg[1] ? 1 : 2));
    end
    $display("capture test done");
    end_of_test();
  end
endmodule : timer_channel_enable_polarity_tb
